// file: common/ctc_defs.svh
// Timing constants of the coax transceiver control block.
`ifndef CTC_DEFS_SVH
`define CTC_DEFS_SVH

// ==========================================================================
// Clock
`define CTC_CLK_NS        25

// ==========================================================================
// Times as given, in their own unit
`define CTC_RX_LOWMIN_NS  25
`define CTC_RX_LOWMAX_NS  100
`define CTC_RX_ON_MAX_NS  500
`define CTC_RX_OFF_NS     250
`define CTC_TX_ON_NS      25
`define CTC_TX_OFF_NS     150
`define CTC_COL_ON_MAX_NS 700
`define CTC_COL_HALF_NS   50
`define CTC_COL_TAIL_NS   170
`define CTC_HB_DELAY_NS   1000
`define CTC_HB_WIDTH_NS   1000
`define CTC_UNJAB_NS      450
`define CTC_JAB_MS        30
`define CTC_POR_MS        400
`define CTC_DISC_MS       800
`define CTC_ANN_MS        400

// ==========================================================================
// Cycle counts; least times round up, transmit off gets one cycle over its floor, longest times round down
`define CTC_CEIL(t)       (((t) + `CTC_CLK_NS - 1) / `CTC_CLK_NS)
`define CTC_RX_LOWMIN_CYC `CTC_CEIL(`CTC_RX_LOWMIN_NS)
`define CTC_RX_LOWMAX_CYC (`CTC_RX_LOWMAX_NS / `CTC_CLK_NS)
`define CTC_RX_ON_MAX_CYC (`CTC_RX_ON_MAX_NS / `CTC_CLK_NS)
`define CTC_RX_OFF_CYC    `CTC_CEIL(`CTC_RX_OFF_NS)
`define CTC_TX_ON_CYC     `CTC_CEIL(`CTC_TX_ON_NS)
`define CTC_TX_OFF_CYC    ((`CTC_TX_OFF_NS / `CTC_CLK_NS) + 1)
`define CTC_COL_ON_CYC    (`CTC_COL_ON_MAX_NS / `CTC_CLK_NS)
`define CTC_COL_HALF_CYC  (`CTC_COL_HALF_NS / `CTC_CLK_NS)
`define CTC_COL_TAIL_CYC  `CTC_CEIL(`CTC_COL_TAIL_NS)
`define CTC_HB_DELAY_CYC  (`CTC_HB_DELAY_NS / `CTC_CLK_NS)
`define CTC_HB_WIDTH_CYC  (`CTC_HB_WIDTH_NS / `CTC_CLK_NS)
`define CTC_UNJAB_CYC     `CTC_CEIL(`CTC_UNJAB_NS)
`define CTC_MS_CYC(m)     ((m) * (1000000 / `CTC_CLK_NS))
`define CTC_JAB_CYC       `CTC_MS_CYC(`CTC_JAB_MS)
`define CTC_POR_CYC       `CTC_MS_CYC(`CTC_POR_MS)
`define CTC_DISC_CYC      `CTC_MS_CYC(`CTC_DISC_MS)
`define CTC_ANN_CYC       `CTC_MS_CYC(`CTC_ANN_MS)

// ==========================================================================
// Synchronised pin positions
`define CTC_PIN_N         7
`define CTC_PIN_RXDAT     0
`define CTC_PIN_RXLVL     1
`define CTC_PIN_COLLVL    2
`define CTC_PIN_TXNEG     3
`define CTC_PIN_UVOK      4
`define CTC_PIN_DISC      5
`define CTC_PIN_HBSTRAP   6
`define CTC_FIFO_DEPTH    16

`endif

// file: common/ctc_pkg.sv
// Types shared by the coax transceiver control block.
package ctc_pkg;

  // ========================================================================
  // State encodings
  typedef enum logic [1:0] {
    CTC_RX_IDLE = 2'h0,
    CTC_RX_LOW  = 2'h1,
    CTC_RX_ON   = 2'h2
  } ctc_rx_st_t;

  typedef enum logic [1:0] {
    CTC_TX_IDLE = 2'h0,
    CTC_TX_ON   = 2'h1,
    CTC_TX_JAB  = 2'h2,
    CTC_TX_UNJ  = 2'h3
  } ctc_tx_st_t;

  typedef enum logic [1:0] {
    CTC_HB_IDLE  = 2'h0,
    CTC_HB_WAIT  = 2'h1,
    CTC_HB_BURST = 2'h2
  } ctc_hb_st_t;

  // ========================================================================
  // Complete state of the top module
  typedef struct packed {
    logic [6:0]  s1;
    logic [6:0]  s2;
    logic [6:0]  s3;
    logic [6:0]  flt;
    ctc_rx_st_t  rx_st;
    logic [4:0]  rx_cnt;
    ctc_tx_st_t  tx_st;
    logic [4:0]  tx_cnt;
    logic [25:0] jab_cnt;
    ctc_hb_st_t  hb_st;
    logic [5:0]  hb_cnt;
    logic        osc_act;
    logic [1:0]  osc_cnt;
    logic [3:0]  tail_cnt;
    logic [25:0] por_cnt;
    logic        por_done;
    logic [25:0] disc_cnt;
    logic        disc_on;
    logic [25:0] ann_cnt;
    logic        rx_out;
    logic        rx_oe_n;
    logic        col_out;
    logic        col_oe_n;
    logic        tx_drive;
    logic        tx_en;
    logic        aui_pwr;
  } ctc_state_t;

endpackage

// file: common/ctc_stream_if.sv
// Valid/ready stream carrier between the control logic and its FIFO.
`timescale 1ns/1ps
interface ctc_stream_if #(parameter int W = 1);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: rtl/ctc_fifo.sv
// Receive data FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module ctc_fifo #(
  parameter int W = 1,
  parameter int D = 16
) (
  input  wire logic   core_clk_i,
  input  wire logic   rst_n_i,
  ctc_stream_if.snk   wr,
  ctc_stream_if.src   rd
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } ctc_fifo_st_t;

  ctc_fifo_st_t st_reg;
  ctc_fifo_st_t st_next;
  logic [W-1:0] mem [D];
  logic         push;
  logic         pop;

  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("FIFO depth must be a power of two of at least 2.");
  end

  assign wr.ready = (st_reg.cnt != (AW+1)'(D));
  assign rd.valid = (st_reg.cnt != '0);
  assign rd.data  = mem[st_reg.rp];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Memory has no reset; only written words are ever read.
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[st_reg.wp] <= wr.data;
    end
  end

  a_fifo_bound: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st_reg.cnt <= (AW+1)'(D))
    else $error("FIFO count above depth.");
endmodule

// file: rtl/ctc_top.sv
// Control logic of a coaxial 10 Mb/s transceiver.
`timescale 1ns/1ps
`include "ctc_defs.svh"
// Function
// [RL1] Receive on after squelch level and timed 01.
// [RL2] Receive turn-on within 500 ns.
// [RL3] Receive off after 250 ns steady high.
// [RL4] AUI drivers powered only when active.
// [RL5] Transmit on after qualified 01 start.
// [RL6] Transmit off after 150 ns without excursion.
// [RL7] Collision level drives 10 MHz burst.
// [RL8] Collision indication within 700 ns.
// [RL9] Burst starts low, ends high over 170 ns.
// [RL10] Collision flagged regardless of local transmit.
// [RL11] Heartbeat burst 1 us after transmit end.
// [RL12] Strap tied low suppresses heartbeat.
// [RL13] Transmit inhibited after 30 ms active.
// [RL14] Jabber collision through packet plus unjab.
// [RL15] Undervoltage keeps both squelches asserted.
// [RL16] Power-up: 400 ms silent and disabled.
// [RL17] Disconnect 800 ms: squelch, drivers high impedance.
// [RL18] Disconnect announced 400 ms, reconnect silent.
// [RL19] No transmit to receive internal path.
// [RL20] All timing counted on one clock.
module ctc_top #(
  parameter int JAB_CYC  = `CTC_JAB_CYC,
  parameter int POR_CYC  = `CTC_POR_CYC,
  parameter int DISC_CYC = `CTC_DISC_CYC,
  parameter int ANN_CYC  = `CTC_ANN_CYC,
  parameter int FIFO_D   = `CTC_FIFO_DEPTH
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic cable_sense_in_i,
  input  wire logic receive_squelch_threshold_i,
  input  wire logic collision_level_i,
  input  wire logic tx_neg_excursion_i,
  input  wire logic undervoltage_threshold_i,
  input  wire logic disconnect_threshold_i,
  input  wire logic heartbeat_strap_i,
  output logic      rx_pair_out_o,
  output logic      rx_pair_oe_n_o,
  output logic      collision_pair_out_o,
  output logic      collision_pair_oe_n_o,
  output logic      cable_drive_out_o,
  output logic      tx_enable_o,
  output logic      aui_power_o
);
  import ctc_pkg::*;

  // ==========================================================================
  // Constants and elaboration checks
  localparam int RXOFF = `CTC_RX_OFF_CYC;
  localparam int TXOFF = `CTC_TX_OFF_CYC;
  localparam int LOMIN = `CTC_RX_LOWMIN_CYC;
  localparam int LOMAX = `CTC_RX_LOWMAX_CYC;
  localparam int HALF  = `CTC_COL_HALF_CYC;
  localparam int TAIL  = `CTC_COL_TAIL_CYC;
  localparam int HBDLY = `CTC_HB_DELAY_CYC;
  localparam int HBW   = `CTC_HB_WIDTH_CYC;
  localparam int UNJAB = `CTC_UNJAB_CYC;

  if (JAB_CYC < 2 || POR_CYC < 2 || DISC_CYC < 2 || ANN_CYC < 2 ||
      JAB_CYC >= (1 << 26) || POR_CYC >= (1 << 26) ||
      DISC_CYC >= (1 << 26) || ANN_CYC >= (1 << 26)) begin : g_chk
    $error("Long counts must lie between 2 and 2**26-1.");
  end

  ctc_state_t st_reg;
  ctc_state_t st_next;
  logic [`CTC_PIN_N-1:0] pins;

  ctc_stream_if #(.W(1)) fin ();
  ctc_stream_if #(.W(1)) fout ();

  ctc_fifo #(
    .W (1),
    .D (FIFO_D)
  ) u_fifo (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .wr         (fin.snk),
    .rd         (fout.src)
  );

  assign pins = {heartbeat_strap_i, disconnect_threshold_i,
                 undervoltage_threshold_i, tx_neg_excursion_i,
                 collision_level_i, receive_squelch_threshold_i,
                 cable_sense_in_i};

  // ==========================================================================
  // Decoded conditions
  logic sq_ok;
  logic col_req;
  logic jab_col;

  // Squelch is lifted only after power-up, above lockout, cable present.
  assign sq_ok = st_reg.por_done & st_reg.flt[`CTC_PIN_UVOK] &
                 ~st_reg.disc_on;  // see RL15 see RL16 see RL17
  assign jab_col = (st_reg.tx_st == CTC_TX_JAB) |
                   (st_reg.tx_st == CTC_TX_UNJ);  // see RL14
  // Cable level is watched regardless of what the local DTE is doing.
  assign col_req = st_reg.por_done & st_reg.flt[`CTC_PIN_UVOK] &
                   ((~st_reg.disc_on & st_reg.flt[`CTC_PIN_COLLVL]) |
                    (st_reg.hb_st == CTC_HB_BURST) | jab_col |
                    (st_reg.ann_cnt != '0));  // see RL10 see RL18

  // Received data only ever comes from the cable sense pin.
  assign fin.valid  = (st_reg.rx_st == CTC_RX_ON);  // see RL19
  assign fin.data   = st_reg.flt[`CTC_PIN_RXDAT];
  // Draining stalls while squelched; CTC_RX_ON ends a cycle later, so the FIFO holds two words at most.
  assign fout.ready = sq_ok;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    st_next = st_reg;

    // Three-stage synchroniser; a change counts when stages two and three
    // agree.
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < `CTC_PIN_N; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.flt[i] = st_reg.s3[i];
      end
    end

    // Power-up hold-off.
    if (!st_reg.por_done) begin  // see RL16 see RL20
      st_next.por_cnt = st_reg.por_cnt + 26'h1;
      if (st_reg.por_cnt == 26'(POR_CYC - 1)) begin
        st_next.por_done = 1'b1;
      end
    end

    // Disconnect detection with announcement on entering disconnect only.
    if (st_reg.flt[`CTC_PIN_DISC] && st_reg.por_done) begin
      if (!st_reg.disc_on) begin
        st_next.disc_cnt = st_reg.disc_cnt + 26'h1;
        if (st_reg.disc_cnt == 26'(DISC_CYC - 1)) begin
          st_next.disc_on = 1'b1;  // see RL17
          st_next.ann_cnt = 26'(ANN_CYC);  // see RL18
        end
      end
    end else begin
      st_next.disc_cnt = '0;
      st_next.disc_on  = 1'b0;
    end
    if (st_reg.ann_cnt != '0) begin
      st_next.ann_cnt = st_reg.ann_cnt - 26'h1;
    end

    // Receive squelch: level plus a correctly timed 01 start.
    unique case (st_reg.rx_st)
      CTC_RX_IDLE: begin
        st_next.rx_cnt = '0;
        if (sq_ok && st_reg.flt[`CTC_PIN_RXLVL] &&
            !st_reg.flt[`CTC_PIN_RXDAT]) begin
          st_next.rx_st  = CTC_RX_LOW;  // see RL1
          st_next.rx_cnt = 5'h1;
        end
      end
      CTC_RX_LOW: begin
        if (!sq_ok || !st_reg.flt[`CTC_PIN_RXLVL]) begin
          st_next.rx_st = CTC_RX_IDLE;
        end else if (!st_reg.flt[`CTC_PIN_RXDAT]) begin
          // An overlong low saturates here instead of re-arming from idle,
          // so its trailing part can never pass as a timed 01 start.
          if (st_reg.rx_cnt <= 5'(LOMAX)) begin
            st_next.rx_cnt = st_reg.rx_cnt + 5'h1;
          end
        end else if (st_reg.rx_cnt >= 5'(LOMIN) &&
                     st_reg.rx_cnt <= 5'(LOMAX)) begin
          st_next.rx_st  = CTC_RX_ON;  // see RL1 see RL2
          st_next.rx_cnt = '0;
        end else begin
          st_next.rx_st = CTC_RX_IDLE;
        end
      end
      CTC_RX_ON: begin
        if (!st_reg.flt[`CTC_PIN_RXDAT]) begin
          st_next.rx_cnt = '0;
        end else begin
          st_next.rx_cnt = st_reg.rx_cnt + 5'h1;
        end
        if (!sq_ok || !st_reg.flt[`CTC_PIN_RXLVL] ||
            (st_reg.flt[`CTC_PIN_RXDAT] &&
             st_reg.rx_cnt == 5'(RXOFF - 1))) begin
          st_next.rx_st = CTC_RX_IDLE;  // see RL3
        end
      end
      default: begin
        st_next.rx_st = CTC_RX_IDLE;
      end
    endcase

    // Transmit squelch and jabber.
    unique case (st_reg.tx_st)
      CTC_TX_IDLE: begin
        st_next.tx_cnt  = '0;
        st_next.jab_cnt = '0;
        if (sq_ok && st_reg.flt[`CTC_PIN_TXNEG]) begin
          st_next.tx_st = CTC_TX_ON;  // see RL5
        end
      end
      CTC_TX_ON, CTC_TX_JAB: begin
        st_next.tx_cnt = st_reg.flt[`CTC_PIN_TXNEG] ? 5'h0 :
                         st_reg.tx_cnt + 5'h1;
        st_next.jab_cnt = st_reg.jab_cnt + 26'h1;
        if (st_reg.tx_st == CTC_TX_ON &&
            st_reg.jab_cnt == 26'(JAB_CYC - 1)) begin
          st_next.tx_st = CTC_TX_JAB;  // see RL13
        end
        if (!st_reg.flt[`CTC_PIN_TXNEG] &&
            st_reg.tx_cnt == 5'(TXOFF - 1)) begin
          st_next.tx_cnt = '0;
          if (st_reg.tx_st == CTC_TX_JAB) begin
            st_next.tx_st = CTC_TX_UNJ;  // see RL14
          end else begin
            st_next.tx_st = CTC_TX_IDLE;  // see RL6
            if (st_reg.flt[`CTC_PIN_HBSTRAP]) begin
              st_next.hb_st  = CTC_HB_WAIT;  // see RL11 see RL12
              st_next.hb_cnt = '0;
            end
          end
        end else if (!sq_ok) begin
          st_next.tx_st = CTC_TX_IDLE;  // see RL15
        end
      end
      CTC_TX_UNJ: begin
        st_next.tx_cnt = st_reg.tx_cnt + 5'h1;
        if (st_reg.tx_cnt == 5'(UNJAB - 1)) begin
          st_next.tx_st = CTC_TX_IDLE;  // see RL14
        end
      end
    endcase

    // Heartbeat: wait, then one burst window.
    unique case (st_reg.hb_st)
      CTC_HB_IDLE: begin
        st_next.hb_cnt = '0;
      end
      CTC_HB_WAIT: begin
        st_next.hb_cnt = st_reg.hb_cnt + 6'h1;
        if (st_reg.hb_cnt == 6'(HBDLY - 1)) begin
          st_next.hb_st  = CTC_HB_BURST;  // see RL11
          st_next.hb_cnt = '0;
        end
      end
      CTC_HB_BURST: begin
        st_next.hb_cnt = st_reg.hb_cnt + 6'h1;
        if (st_reg.hb_cnt == 6'(HBW - 1)) begin
          st_next.hb_st = CTC_HB_IDLE;
        end
      end
      default: begin
        st_next.hb_st = CTC_HB_IDLE;
      end
    endcase

    // 10 MHz burst generator. A burst only ends on a high half so the
    // tail always follows a rising edge.
    if (st_reg.osc_act) begin
      st_next.osc_cnt = st_reg.osc_cnt + 2'h1;
      st_next.col_out = (st_next.osc_cnt >= 2'(HALF));  // see RL7
      if (!col_req && st_reg.osc_cnt == 2'(2 * HALF - 1)) begin
        st_next.osc_act  = 1'b0;
        st_next.col_out  = 1'b1;
        st_next.tail_cnt = 4'(TAIL);  // see RL9
      end
    end else if (st_reg.tail_cnt != '0) begin
      st_next.tail_cnt = st_reg.tail_cnt - 4'h1;
    end else if (col_req) begin
      st_next.osc_act = 1'b1;  // see RL8
      st_next.osc_cnt = '0;
      st_next.col_out = 1'b0;  // see RL9
    end

    // Registered pin outputs.
    st_next.aui_pwr  = (st_next.rx_st == CTC_RX_ON) | st_next.osc_act |
                       (st_next.tail_cnt != '0) | fout.valid;  // see RL4
    st_next.rx_out   = (fout.valid && sq_ok) ? fout.data : 1'b1;
    st_next.rx_oe_n  = ~(st_next.aui_pwr & ~st_next.disc_on);  // see RL17
    st_next.col_oe_n = ~((st_next.osc_act | (st_next.tail_cnt != '0)) &
                         (~st_next.disc_on | st_next.ann_cnt != '0));
    st_next.tx_en    = (st_next.tx_st == CTC_TX_ON);  // see RL13
    st_next.tx_drive = st_next.tx_en & st_reg.flt[`CTC_PIN_TXNEG];
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg          <= '0;
      st_reg.rx_out   <= 1'b1;
      st_reg.col_out  <= 1'b1;
      st_reg.rx_oe_n  <= 1'b1;
      st_reg.col_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rx_pair_out_o         = st_reg.rx_out;
  assign rx_pair_oe_n_o        = st_reg.rx_oe_n;
  assign collision_pair_out_o  = st_reg.col_out;
  assign collision_pair_oe_n_o = st_reg.col_oe_n;
  assign cable_drive_out_o     = st_reg.tx_drive;
  assign tx_enable_o           = st_reg.tx_en;
  assign aui_power_o           = st_reg.aui_pwr;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_rx_on_cause: assert property (  // see RL1
    $rose(st_reg.rx_st == CTC_RX_ON) |->
      $past(st_reg.flt[`CTC_PIN_RXLVL]) && $past(st_reg.flt[`CTC_PIN_RXDAT]))
    else $error("Receive on without level or 01 start.");
  a_rx_on_time: assert property (  // see RL2
    st_reg.rx_st == CTC_RX_LOW |-> st_reg.rx_cnt <= 5'h14)
    else $error("Receive turn-on slower than 500 ns.");
  a_rx_off_high: assert property (  // see RL3
    (st_reg.rx_st == CTC_RX_ON && sq_ok && st_reg.flt[`CTC_PIN_RXLVL])[*3]
      ##1 st_reg.rx_st != CTC_RX_ON |-> $past(st_reg.rx_cnt) == 5'h9)
    else $error("Receive off without 250 ns high.");
  a_tx_off_quiet: assert property (  // see RL6
    st_reg.tx_st == CTC_TX_ON && !st_reg.flt[`CTC_PIN_TXNEG] &&
      st_reg.tx_cnt == 5'h6 && sq_ok |=> st_reg.tx_st == CTC_TX_IDLE)
    else $error("Transmit not off after 150 ns quiet.");
  a_col_start_low: assert property (  // see RL9
    $rose(st_reg.osc_act) |-> !st_reg.col_out ##1 !st_reg.col_out
      ##1 st_reg.col_out ##1 st_reg.col_out)
    else $error("Collision burst not starting low at 10 MHz.");
  a_col_tail: assert property (  // see RL9
    $fell(st_reg.osc_act) |-> st_reg.col_out [*7])
    else $error("Collision tail shorter than 170 ns.");
  a_col_latency: assert property (  // see RL8
    col_req && !st_reg.osc_act |-> ##[1:27] st_reg.osc_act)
    else $error("Collision indication later than 700 ns.");
  a_hb_delay: assert property (  // see RL11
    $rose(st_reg.hb_st == CTC_HB_WAIT) |->
      ##40 st_reg.hb_st == CTC_HB_BURST ##40 st_reg.hb_st == CTC_HB_IDLE)
    else $error("Heartbeat window mistimed.");
  a_hb_strap: assert property (  // see RL12
    $rose(st_reg.hb_st == CTC_HB_WAIT) |-> $past(st_reg.flt[`CTC_PIN_HBSTRAP]))
    else $error("Heartbeat despite strap low.");
  a_jab_inhibit: assert property (  // see RL13
    jab_col |-> !st_reg.tx_en)
    else $error("Transmit enabled while jabbering.");
  a_uv_squelch: assert property (  // see RL15
    !st_reg.flt[`CTC_PIN_UVOK] |=> !tx_enable_o && st_reg.rx_st != CTC_RX_ON)
    else $error("Squelch lifted under voltage lockout.");
  a_por_silent: assert property (  // see RL16
    !st_reg.por_done |-> st_reg.col_oe_n && !st_reg.tx_en)
    else $error("Activity during power-up hold-off.");
  a_disc_hiz: assert property (  // see RL17
    st_reg.disc_on && st_reg.ann_cnt == '0 |=> st_reg.col_oe_n)
    else $error("Drivers active after disconnect.");

  c_rx_packet: cover property ($fell(st_reg.rx_st == CTC_RX_ON));
  c_tx_hb: cover property (st_reg.hb_st == CTC_HB_BURST);
  c_jabber: cover property ($rose(st_reg.tx_st == CTC_TX_UNJ));
  c_disc: cover property ($rose(st_reg.disc_on));
endmodule

// file: verification/ctc_dte_model.sv
// Behavioural DTE transmit side that sends excursion bursts.
`timescale 1ns/1ps
module ctc_dte_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       send_i,
  input  wire logic [7:0] len_i,
  output logic            tx_neg_excursion_o
);
  logic [7:0] cnt_reg;
  logic [1:0] ph_reg;
  // Runs on the falling edge so the block sees its input change between
  // its own sampling edges.  Each packet opens with a two-cycle excursion,
  // wider than the qualifying width, and gaps stay far below the off time.
  always_ff @(negedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 8'h0;
      ph_reg  <= 2'h0;
    end else if (send_i) begin
      cnt_reg <= len_i;
      ph_reg  <= 2'h0;
    end else if (cnt_reg != 8'h0) begin
      cnt_reg <= cnt_reg - 8'h1;
      ph_reg  <= ph_reg + 2'h1;
    end
  end
  assign tx_neg_excursion_o = (cnt_reg != 8'h0) && !ph_reg[1];
endmodule

// file: verification/tb.sv
// Self-checking testbench of the coax transceiver control block.
`timescale 1ns/1ps
module tb;
  logic       clk = 0, rst_n = 0, dat = 1, sq = 0, col = 0;
  logic       uv = 1, disc = 0, hb = 1, send = 0;
  logic [7:0] len = 8'h0;
  logic       rxo, rxoe_n, cdo, cdoe_n, txd, txen, pwr, exc;
  int         mismatches = 0;
  int         compares = 0;
  always #12.5 clk = ~clk;
  ctc_top #(.JAB_CYC(50), .POR_CYC(20), .DISC_CYC(30), .ANN_CYC(20)) dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .cable_sense_in_i(dat),
    .receive_squelch_threshold_i(sq), .collision_level_i(col),
    .tx_neg_excursion_i(exc), .undervoltage_threshold_i(uv),
    .disconnect_threshold_i(disc), .heartbeat_strap_i(hb),
    .rx_pair_out_o(rxo), .rx_pair_oe_n_o(rxoe_n),
    .collision_pair_out_o(cdo), .collision_pair_oe_n_o(cdoe_n),
    .cable_drive_out_o(txd), .tx_enable_o(txen), .aui_power_o(pwr));
  ctc_dte_model dte (.core_clk_i(clk), .rst_n_i(rst_n), .send_i(send),
    .len_i(len), .tx_neg_excursion_o(exc));
  // ==========================================================================
  // Shared helpers
  task give_verdict;
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic s, input logic e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask
  function logic o(input int k);
    case (k)
      0: o = rxoe_n;
      1: o = cdoe_n;
      2: o = txen;
      4: o = txd;
      default: o = cdo;
    endcase
  endfunction
  task wt(input string nm, input int k, input logic v, input int n);
    bit hit;
    hit = 0;
    for (int i = 0; i < n && !hit; i++) begin
      @(negedge clk);
      hit = (o(k) === v);
    end
    chk(nm, hit, 1'b1);
  endtask
  task hold(input string nm, input int k, input logic v, input int n);
    bit ok;
    ok = 1;
    repeat (n) begin
      @(negedge clk);
      if (o(k) !== v) ok = 0;
    end
    chk(nm, ok, 1'b1);
  endtask
  task pkt(input logic [7:0] n);
    @(negedge clk);
    send <= 1'b1;
    len <= n;
    @(negedge clk);
    send <= 1'b0;
  endtask
  // ==========================================================================
  // Scenarios
  task t_por;
    chk("rst rx oe", rxoe_n, 1'b1);
    chk("rst cd oe", cdoe_n, 1'b1);
    chk("rst tx en", txen, 1'b0);
    chk("rst power", pwr, 1'b0);
    rst_n = 1;
    col = 1;
    pkt(8'h08);
    hold("por cd", 1, 1'b1, 6);
    hold("por tx", 2, 1'b0, 6);
    col = 0;
    repeat (40) @(negedge clk);
  endtask
  task t_rx;
    bit lo;
    lo = 0;
    sq = 1;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      if (rxo === 1'b0) lo = 1;
      dat = i[1];
    end
    chk("rx on", rxoe_n, 1'b0);
    chk("rx data", lo, 1'b1);
    chk("aui power", pwr, 1'b1);
    dat = 1;
    hold("rx stays", 0, 1'b0, 8);
    wt("rx off", 0, 1'b1, 12);
    dat = 0;
    repeat (8) @(negedge clk);
    dat = 1;
    hold("long low", 0, 1'b1, 20);
    sq = 0;
  endtask
  task t_tx;
    pkt(8'h18);
    wt("tx on", 2, 1'b1, 8);
    wt("tx drive", 4, 1'b1, 4);
    hold("no loop", 0, 1'b1, 16);
    chk("tx held", txen, 1'b1);
    wt("tx off", 2, 1'b0, 24);
    hold("hb gap", 1, 1'b1, 28);
    wt("hb on", 1, 1'b0, 24);
    wt("hb end", 1, 1'b1, 60);
    chk("aui idle", pwr, 1'b0);
    hb = 0;
    pkt(8'h18);
    wt("tx on2", 2, 1'b1, 8);
    wt("tx off2", 2, 1'b0, 40);
    hold("hb none", 1, 1'b1, 100);
    hb = 1;
  endtask
  task t_col;
    logic [3:0] pat;
    int         run;
    pat = 4'h6;
    run = 0;
    col = 1;
    wt("cd start", 3, 1'b0, 28);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      chk("cd wave", cdo, pat[i]);
    end
    col = 0;
    for (int i = 0; i < 40 && cdoe_n !== 1'b1; i++) begin
      @(negedge clk);
      run = (cdo === 1'b1) ? run + 1 : 0;
    end
    chk("cd tail", run >= 7, 1'b1);
    chk("cd idle", cdoe_n, 1'b1);
  endtask
  task t_jab;
    pkt(8'h64);
    wt("jab tx", 2, 1'b1, 8);
    wt("jab trip", 2, 1'b0, 64);
    wt("jab cd", 1, 1'b0, 8);
    hold("jab hold", 1, 1'b0, 20);
    wt("unjab end", 1, 1'b1, 100);
    pkt(8'h10);
    wt("tx again", 2, 1'b1, 8);
    repeat (120) @(negedge clk);
  endtask
  task t_disc;
    disc = 1;
    hold("disc wait", 1, 1'b1, 24);
    wt("disc ann", 1, 1'b0, 20);
    chk("disc rx", rxoe_n, 1'b1);
    hold("ann len", 1, 1'b0, 14);
    wt("disc hiz", 1, 1'b1, 30);
    pkt(8'h10);
    hold("disc tx", 2, 1'b0, 20);
    disc = 0;
    hold("reconnect", 1, 1'b1, 40);
  endtask
  task t_uv;
    uv = 0;
    repeat (6) @(negedge clk);
    pkt(8'h10);
    hold("uv tx", 2, 1'b0, 30);
    uv = 1;
  endtask
  // ==========================================================================
  // Sequence and watchdog
  initial begin
    repeat (16) @(negedge clk);
    t_por;
    t_rx;
    t_tx;
    t_col;
    t_jab;
    t_disc;
    t_uv;
    give_verdict;
  end
  initial begin
    #100000;
    mismatches++;
    give_verdict;
  end
endmodule
